// ### rtl/oip_chan.sv
// Power-limit slice for one output channel
`default_nettype none
module oip_chan
    import oip_pkg::*;
#(
    parameter int SHUT_CYCLES = SHUT_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Channel link
    oip_chan_if.chan c
);
    logic        active;
    logic        over;
    logic [15:0] cnt;
    logic        trip;

    assign active = c.ceiling < CHAN_MAX_W;
    assign over   = active && (c.power > c.ceiling);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 16'h0000;
        end else if (!over || !c.shut_type || trip) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trip <= 1'b0;
        end else if (over && c.shut_type && cnt == 16'(SHUT_CYCLES - 1)) begin
            trip <= 1'b1;
        end else if (c.clear) begin
            trip <= 1'b0;
        end
    end

    assign c.regulate = over && !c.shut_type;
    assign c.flag     = c.regulate || trip;
    assign c.trip     = trip;

    a_max_no_limit: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (c.ceiling >= CHAN_MAX_W) |-> !c.regulate && !over)
        else $error("limit engaged at max ceiling");

    a_trip_timing: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (over && c.shut_type && !trip && cnt == 16'(SHUT_CYCLES - 1)) |=> trip && c.flag)
        else $error("shutdown channel did not trip on time");
endmodule : oip_chan
`default_nettype wire

// ### rtl/oip_chan_if.sv
// Per-channel signals between the top and a channel power-limit slice
`default_nettype none
interface oip_chan_if;
    logic [11:0] power;
    logic [11:0] ceiling;
    logic        shut_type;
    logic        clear;
    logic        flag;
    logic        trip;
    logic        regulate;
    modport top  (output power, ceiling, shut_type, clear, input flag, trip, regulate);
    modport chan (input power, ceiling, shut_type, clear, output flag, trip, regulate);
endinterface : oip_chan_if
`default_nettype wire

// ### rtl/oip_pkg.sv
// Constants and types for the output inhibit and power protection block
`default_nettype none
package oip_pkg;
    localparam int          CLK_PERIOD_NS  = 50;
    localparam int          INH_LAT_NS     = 5000;
    localparam int          INH_LAT_CYC    = INH_LAT_NS / CLK_PERIOD_NS;
    localparam int          SHUT_TIME_NS   = 1000000;
    localparam int          SHUT_CYC       = SHUT_TIME_NS / CLK_PERIOD_NS;
    localparam int          NCHAN          = 4;
    localparam int          PW             = 12;
    localparam int          SW             = 14;
    localparam logic [11:0] CHAN_MAX_W     = 12'h1F4;
    localparam logic [13:0] FRAME_HI_W     = 14'h04B0;
    localparam logic [13:0] FRAME_LO_W     = 14'h0258;
    localparam logic [13:0] LOWLINE_SUM_W  = 14'h0258;
    localparam logic [2:0]  PIN_INHIBIT    = 3'h3;
    localparam logic [2:0]  PIN_SYNC_FIRST = 3'h4;
    localparam logic [2:0]  FUNC_DIO       = 3'h0;
    localparam logic [2:0]  FUNC_INHIBIT   = 3'h1;
    localparam logic [2:0]  FUNC_OUTSTATE  = 3'h2;
    localparam logic [2:0]  FUNC_FAULT     = 3'h3;
    typedef enum logic [1:0] {OIP_MODE_OFF, OIP_MODE_LATCH, OIP_MODE_LIVE} oip_mode_t;
endpackage : oip_pkg
`default_nettype wire

// ### rtl/oip_top.sv
// Remote inhibit, fault chaining and power protection control
// What this block does
// - Software enables inhibit on pin 3 only; polarity input picks true level
// - Act on inhibit change within 5 us
// - Latched mode: true edge disables all outputs
// - Live mode: outputs follow inhibit input
// - Off mode ignores inhibit input entirely
// - Inhibit mode kept in non-volatile storage
// - Inhibit disable also asserts fault output
// - Chained fault stays until explicitly cleared
// - Output-state function only on pins 4-7
// - Frame over-power turns all outputs off
// - Frame power fault sets status flag
// - Channel limit engages only below maximum
// - Regulating channels hold limit, flag, recover
// - Shutdown channels trip after about 1 ms
// - Low line rejects ceiling sum over 600W
// - Reset restores maximum ceiling; max write too unless low-line sum over 600W
// - Polarity picks high or low as true
// - Fault output latched until protect_clear or off-mode write with cause gone
`default_nettype none
module oip_top
    import oip_pkg::*;
#(
    parameter int SHUT_CYCLES = SHUT_CYC
) (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    // Pins
    input  wire logic                   disable_pin_in,
    output logic                        fault_out,
    // Pin function and polarity
    input  wire logic                   func_wr,
    input  wire logic [2:0]             func_pin,
    input  wire logic [2:0]             func_sel,
    input  wire logic                   disable_pin_polarity,
    output logic                        func_reject,
    output logic                        remote_disable_function,
    // Inhibit mode and its non-volatile copy
    input  wire logic                   mode_wr,
    input  wire oip_pkg::oip_mode_t     disable_mode_setting,
    input  wire oip_pkg::oip_mode_t     mode_nv_value,
    output oip_pkg::oip_mode_t          mode_nv_data,
    output logic                        mode_nv_wr,
    output oip_pkg::oip_mode_t          mode_now,
    // Protection
    input  wire logic                   protect_clear,
    input  wire logic                   low_line,
    output logic                        power_fault_flag,
    // Channels
    input  wire logic [3:0]             chan_out_req,
    input  wire logic [3:0]             chan_shut_type,
    input  wire logic [3:0][11:0]       chan_power,
    output logic [3:0]                  chan_enable,
    output logic [3:0]                  power_limit_flag,
    output logic [3:0]                  chan_regulate,
    // Power ceiling programming
    input  wire logic                   ceil_wr,
    input  wire logic                   ceil_to_max,
    input  wire logic [1:0]             ceil_chan,
    input  wire logic [11:0]            ceil_val,
    output logic                        ceil_reject,
    output logic [3:0][11:0]            channel_power_ceiling
);
    import oip_pkg::*;

    // ------------------------------------------------------------
    // Pin function and polarity
    // ------------------------------------------------------------
    logic pol_pos;
    logic func_bad;

    // Sync function on upper pins only
    assign func_bad = (func_sel == FUNC_OUTSTATE && func_pin < PIN_SYNC_FIRST)
                   || (func_sel == FUNC_INHIBIT && func_pin != PIN_INHIBIT)
                   || func_pin == 3'h0;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            remote_disable_function <= 1'b0;
            pol_pos                 <= 1'b1;
        end else begin
            if (func_wr && !func_bad && func_pin == PIN_INHIBIT) begin
                remote_disable_function <= (func_sel == FUNC_INHIBIT);
            end
            pol_pos <= disable_pin_polarity;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            func_reject <= 1'b0;
        end else begin
            func_reject <= func_wr && func_bad;
        end
    end

    // ------------------------------------------------------------
    // Inhibit mode with non-volatile copy
    // ------------------------------------------------------------
    oip_mode_t mode;
    logic      nv_loaded;
    logic      mode_off_evt;

    assign mode_off_evt = mode_wr && disable_mode_setting == OIP_MODE_OFF;

    // Restore after reset, store on write
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode         <= OIP_MODE_OFF;
            nv_loaded    <= 1'b0;
            mode_nv_wr   <= 1'b0;
            mode_nv_data <= OIP_MODE_OFF;
        end else begin
            nv_loaded  <= 1'b1;
            mode_nv_wr <= mode_wr;
            if (mode_wr) begin
                mode         <= disable_mode_setting;
                mode_nv_data <= disable_mode_setting;
            end else if (!nv_loaded) begin
                mode <= mode_nv_value;
            end
        end
    end

    assign mode_now = mode;

    // ------------------------------------------------------------
    // Inhibit input path
    // ------------------------------------------------------------
    logic pin_s1;
    logic pin_s2;
    logic inh_true;
    logic inh_prev;
    logic inh_latch;
    logic live_block;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
        end else begin
            pin_s1 <= disable_pin_in;
            pin_s2 <= pin_s1;
        end
    end

    assign inh_true = remote_disable_function && (pol_pos ? pin_s2 : !pin_s2);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            inh_prev <= 1'b0;
        end else begin
            inh_prev <= inh_true;
        end
    end

    // Latch on true edge; off clears it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            inh_latch <= 1'b0;
        end else if (mode == OIP_MODE_LATCH && inh_true && !inh_prev && !mode_wr) begin
            inh_latch <= 1'b1;
        end else if (mode_off_evt || mode == OIP_MODE_OFF) begin
            inh_latch <= 1'b0;
        end
    end

    assign live_block = mode == OIP_MODE_LIVE && inh_true;

    // ------------------------------------------------------------
    // Frame power fault
    // ------------------------------------------------------------
    logic [13:0] power_sum;
    logic [13:0] frame_limit;

    always_comb begin
        power_sum = 14'h0000;
        for (int i = 0; i < NCHAN; i++) begin
            power_sum = power_sum + 14'(chan_power[i]);
        end
    end

    assign frame_limit = low_line ? FRAME_LO_W : FRAME_HI_W;

    // Sticky flag, set wins over clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            power_fault_flag <= 1'b0;
        end else if (power_sum > frame_limit) begin
            power_fault_flag <= 1'b1;
        end else if (protect_clear) begin
            power_fault_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Channel power ceilings
    // ------------------------------------------------------------
    logic [13:0] ceil_sum;
    logic        ceil_bad;

    always_comb begin
        ceil_sum = 14'h0000;
        for (int i = 0; i < NCHAN; i++) begin
            if (2'(i) == ceil_chan) begin
                ceil_sum = ceil_sum + 14'(ceil_to_max ? CHAN_MAX_W : ceil_val);
            end else begin
                ceil_sum = ceil_sum + 14'(channel_power_ceiling[i]);
            end
        end
    end

    assign ceil_bad = (!ceil_to_max && ceil_val > CHAN_MAX_W)
                   || (low_line && ceil_sum > LOWLINE_SUM_W);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NCHAN; i++) begin
                channel_power_ceiling[i] <= CHAN_MAX_W;
            end
        end else if (ceil_wr && !ceil_bad) begin
            channel_power_ceiling[ceil_chan] <= ceil_to_max ? CHAN_MAX_W : ceil_val;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ceil_reject <= 1'b0;
        end else begin
            ceil_reject <= ceil_wr && ceil_bad;
        end
    end

    // ------------------------------------------------------------
    // Channel slices
    // ------------------------------------------------------------
    logic [3:0] trip;
    logic [3:0] flag;
    logic [3:0] regulate;

    for (genvar g = 0; g < NCHAN; g++) begin : g_chan
        oip_chan_if cif ();
        assign cif.power     = chan_power[g];
        assign cif.ceiling   = channel_power_ceiling[g];
        assign cif.shut_type = chan_shut_type[g];
        assign cif.clear     = protect_clear;
        assign trip[g]       = cif.trip;
        assign flag[g]       = cif.flag;
        assign regulate[g]   = cif.regulate;
        oip_chan #(
            .SHUT_CYCLES (SHUT_CYCLES)
        ) u_chan (
            .mclk  (mclk),
            .rst_b (rst_b),
            .c     (cif)
        );
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            power_limit_flag <= 4'h0;
            chan_regulate    <= 4'h0;
        end else begin
            power_limit_flag <= flag;
            chan_regulate    <= regulate;
        end
    end

    // ------------------------------------------------------------
    // Output enables and fault output
    // ------------------------------------------------------------
    logic all_block;

    assign all_block = inh_latch || live_block || power_fault_flag;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            chan_enable <= 4'h0;
        end else begin
            chan_enable <= all_block ? 4'h0 : (chan_out_req & ~trip);
        end
    end

    // Inhibit raises fault; held until cleared
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fault_out <= 1'b0;
        end else if ((inh_latch && !mode_off_evt) || live_block || power_fault_flag
                     || (|trip)) begin
            fault_out <= 1'b1;
        end else if (protect_clear || mode_off_evt) begin
            fault_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_inhibit_latency: assert property (
        @(posedge mclk) disable iff (!rst_b)
        ($rose(disable_pin_in) && pol_pos && remote_disable_function
         && mode == OIP_MODE_LIVE && !mode_wr) |-> ##[1:5] chan_enable == 4'h0)
        else $error("inhibit not applied within latency");

    a_latch_holds: assert property (
        @(posedge mclk) disable iff (!rst_b)
        inh_latch |=> chan_enable == 4'h0 && (inh_latch || $past(mode_off_evt)
                                              || mode == OIP_MODE_OFF))
        else $error("latched inhibit released outputs");

    a_live_follow: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (mode == OIP_MODE_LIVE && !inh_true && !inh_latch && !power_fault_flag && trip == 4'h0)
        |=> chan_enable == $past(chan_out_req))
        else $error("live mode did not restore outputs");

    a_off_ignores: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (mode == OIP_MODE_OFF && !power_fault_flag && trip == 4'h0)
        |=> chan_enable == $past(chan_out_req))
        else $error("off mode gated outputs");

    a_fault_chain: assert property (
        @(posedge mclk) disable iff (!rst_b)
        live_block |=> fault_out)
        else $error("inhibit did not raise fault output");

    a_fault_sticky: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (fault_out && !protect_clear && !mode_off_evt) |=> fault_out)
        else $error("fault output dropped without clear");

    a_sync_reject: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (func_wr && func_sel == FUNC_OUTSTATE && func_pin < PIN_SYNC_FIRST) |=> func_reject)
        else $error("output-state function accepted on low pin");

    a_frame_off: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (power_sum > frame_limit) |=> power_fault_flag ##1 chan_enable == 4'h0)
        else $error("frame overload did not shut outputs");

    a_lowline_reject: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (ceil_wr && low_line && ceil_sum > LOWLINE_SUM_W)
        |=> ceil_reject && channel_power_ceiling == $past(channel_power_ceiling))
        else $error("low line ceiling sum accepted");

    a_off_clears: assert property (
        @(posedge mclk) disable iff (!rst_b)
        mode_off_evt |=> !inh_latch)
        else $error("off mode left latch set");
endmodule : oip_top
`default_nettype wire

// ### test/oip_far_peer.sv
// Far-side switch that shorts the disable pin to common
`default_nettype none
module oip_far_peer (
    // Clock
    input  wire logic mclk,
    // Bench control
    input  wire logic short_req,
    input  wire logic slow,
    // Pin
    output logic      pin
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] lag;

    initial lag = 4'h0;

    // Slow answer: the contact closes four cycles late
    always @(posedge mclk) begin
        lag <= {lag[2:0], short_req};
    end

    assign pin = (slow ? lag[3] : short_req) ? 1'b0 : 1'b1;
endmodule : oip_far_peer
`default_nettype wire

// ### test/test_output_inhibit_power_protection.sv
// Self-checking bench for the inhibit and power protection block
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_output_inhibit_power_protection;
    import oip_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int SHUT = 20;
    typedef struct {logic [2:0] pin; logic [2:0] sel; logic rej;} oip_frow_t;
    oip_frow_t rows [8] = '{'{3'h3, 3'h1, 1'h0}, '{3'h2, 3'h1, 1'h1}, '{3'h3, 3'h2, 1'h1},
        '{3'h4, 3'h2, 1'h0}, '{3'h7, 3'h2, 1'h0}, '{3'h0, 3'h0, 1'h1}, '{3'h5, 3'h0, 1'h0},
        '{3'h1, 3'h3, 1'h0}};

    logic mclk = 1'b0, rst_b = 1'b0, pin, fault_out, func_wr = 1'b0, pol = 1'b0;
    logic [2:0] func_pin = 3'h0, func_sel = 3'h0;
    logic func_reject, rdf, mode_wr = 1'b0, nv_wr, protect_clear = 1'b0, low_line = 1'b0, pff;
    oip_mode_t mode_set = OIP_MODE_OFF, nv_value = OIP_MODE_LIVE, nv_data, mode_now;
    logic [3:0] out_req = 4'hF, shut_type = 4'h0, enable, plf, regulate;
    logic [3:0][11:0] power = {4{12'h064}}, ceiling;
    logic ceil_wr = 1'b0, ceil_to_max = 1'b0, ceil_reject, short_req = 1'b0, slow = 1'b0;
    logic [1:0] ceil_chan = 2'h0;
    logic [11:0] ceil_val = 12'h000;
    int failures = 0, total_checks = 0;

    always #25 mclk = ~mclk;

    oip_far_peer peer (.mclk(mclk), .short_req(short_req), .slow(slow), .pin(pin));

    oip_top #(.SHUT_CYCLES(SHUT)) dut (
        .mclk(mclk), .rst_b(rst_b), .disable_pin_in(pin), .fault_out(fault_out),
        .func_wr(func_wr), .func_pin(func_pin), .func_sel(func_sel),
        .disable_pin_polarity(pol), .func_reject(func_reject), .remote_disable_function(rdf),
        .mode_wr(mode_wr), .disable_mode_setting(mode_set), .mode_nv_value(nv_value),
        .mode_nv_data(nv_data), .mode_nv_wr(nv_wr), .mode_now(mode_now),
        .protect_clear(protect_clear), .low_line(low_line), .power_fault_flag(pff),
        .chan_out_req(out_req), .chan_shut_type(shut_type), .chan_power(power),
        .chan_enable(enable), .power_limit_flag(plf), .chan_regulate(regulate),
        .ceil_wr(ceil_wr), .ceil_to_max(ceil_to_max), .ceil_chan(ceil_chan),
        .ceil_val(ceil_val), .ceil_reject(ceil_reject), .channel_power_ceiling(ceiling));

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask : tick

    task automatic set_mode(input oip_mode_t m);
        mode_set = m;
        mode_wr = 1'b1;
        tick(1);
        mode_wr = 1'b0;
    endtask : set_mode

    task automatic clear_prot;
        protect_clear = 1'b1;
        tick(1);
        protect_clear = 1'b0;
        tick(1);
    endtask : clear_prot

    task automatic set_ceil(input logic [1:0] ch, input logic [11:0] v, input logic to_max);
        ceil_chan = ch;
        ceil_val = v;
        ceil_to_max = to_max;
        ceil_wr = 1'b1;
        tick(1);
        ceil_wr = 1'b0;
        ceil_to_max = 1'b0;
    endtask : set_ceil

    task automatic print_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #(5000 * 50);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end

    initial begin
        tick(2);
        `CHK(ceiling, {4{CHAN_MAX_W}})
        `CHK(mode_now, OIP_MODE_OFF)
        rst_b = 1'b1;
        tick(2);
        `CHK(mode_now, OIP_MODE_LIVE)
        // Pin function table
        foreach (rows[i]) begin
            func_pin = rows[i].pin;
            func_sel = rows[i].sel;
            func_wr = 1'b1;
            tick(1);
            func_wr = 1'b0;
            `CHK(func_reject, rows[i].rej)
            tick(1);
        end
        `CHK(rdf, 1'b1)
        `CHK(enable, 4'hF)
        // Live mode, switch to common
        short_req = 1'b1;
        tick(2);
        `CHK(enable, 4'hF)
        tick(1);
        `CHK(enable, 4'h0)
        `CHK(fault_out, 1'b1)
        short_req = 1'b0;
        tick(3);
        `CHK(enable, 4'hF)
        `CHK(fault_out, 1'b1)
        clear_prot();
        `CHK(fault_out, 1'b0)
        pol = 1'b1;
        tick(4);
        `CHK(enable, 4'h0)
        pol = 1'b0;
        tick(4);
        clear_prot();
        // Latched mode with a slow switch
        set_mode(OIP_MODE_LATCH);
        `CHK(nv_wr, 1'b1)
        `CHK(nv_data, OIP_MODE_LATCH)
        slow = 1'b1;
        short_req = 1'b1;
        tick(1);
        short_req = 1'b0;
        tick(8);
        `CHK(enable, 4'h0)
        clear_prot();
        tick(4);
        `CHK(enable, 4'h0)
        `CHK(fault_out, 1'b1)
        set_mode(OIP_MODE_OFF);
        tick(1);
        `CHK(enable, 4'hF)
        `CHK(fault_out, 1'b0)
        set_mode(OIP_MODE_LATCH);
        tick(1);
        set_mode(OIP_MODE_OFF);
        slow = 1'b0;
        // Off mode ignores the pin
        short_req = 1'b1;
        tick(5);
        `CHK(enable, 4'hF)
        `CHK(fault_out, 1'b0)
        short_req = 1'b0;
        tick(3);
        // Frame overload 1600 W
        power = {4{12'h190}};
        tick(1);
        `CHK(pff, 1'b1)
        tick(1);
        `CHK(enable, 4'h0)
        clear_prot();
        `CHK(pff, 1'b1)
        power = {4{12'h064}};
        tick(1);
        `CHK(enable, 4'h0)
        clear_prot();
        tick(1);
        `CHK(pff, 1'b0)
        `CHK(enable, 4'hF)
        // Ceiling programming
        set_ceil(2'h0, 12'h064, 1'b0);
        `CHK(ceiling[0], 12'h064)
        low_line = 1'b1;
        tick(1);
        set_ceil(2'h1, 12'h064, 1'b0);
        `CHK(ceil_reject, 1'b1)
        `CHK(ceiling[1], CHAN_MAX_W)
        low_line = 1'b0;
        // Regulating channel at its ceiling
        power[0] = 12'h096;
        power[1] = 12'h300;
        tick(2);
        `CHK(regulate[0], 1'b1)
        `CHK(plf[1:0], 2'h1)
        `CHK(enable[0], 1'b1)
        power[0] = 12'h064;
        power[1] = 12'h064;
        tick(2);
        `CHK(plf[0], 1'b0)
        `CHK(regulate[0], 1'b0)
        // Shutdown channel trips
        shut_type[2] = 1'b1;
        set_ceil(2'h2, 12'h064, 1'b0);
        power[2] = 12'h096;
        tick(SHUT - 5);
        `CHK(enable[2], 1'b1)
        tick(10);
        `CHK(enable, 4'hB)
        `CHK(plf[2], 1'b1)
        power[2] = 12'h064;
        tick(2);
        `CHK(plf[2], 1'b1)
        clear_prot();
        tick(1);
        `CHK(plf[2], 1'b0)
        `CHK(enable, 4'hF)
        // shutdown channel 2 and channel 0 back to max
        set_ceil(2'h2, 12'h000, 1'b1);
        `CHK(ceiling[2], CHAN_MAX_W)
        tick(1);
        set_ceil(2'h0, 12'h000, 1'b1);
        `CHK(ceiling[0], CHAN_MAX_W)
        print_verdict();
    end
endmodule : test_output_inhibit_power_protection
`default_nettype wire
